// [hdl/sdt_pkg.sv]
package sdt_pkg;

  // Control register location and value after reset
  localparam logic [7:0] CTRL_ADDR    = 8'hc8;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  // Writable bits; bits 4 and 1 read as zero
  localparam logic [7:0] CTRL_RW_MASK = 8'hed;

  // Control register field positions
  localparam int UPPER_FLAG_BIT  = 7;
  localparam int LOWER_FLAG_BIT  = 6;
  localparam int LOWER_IRQ_BIT   = 5;
  localparam int SPLIT_BIT       = 3;
  localparam int RUN_BIT         = 2;
  localparam int EXT_SEL_BIT     = 0;

  // Clock source division counts
  localparam int SYS_DIV_COUNT   = 12;
  localparam int EXT_DIV_COUNT   = 8;

  // Counter limits and reset values
  localparam logic [7:0] COUNT_MAX   = 8'hff;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // Counter index in the per-counter arrays
  localparam int LOWER_IDX = 0;
  localparam int UPPER_IDX = 1;

endpackage : sdt_pkg

// [hdl/sdt_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface sdt_tick_if;
  logic sys_div_tick;
  logic ext_div_tick;

  modport gen (
    output sys_div_tick,
    output ext_div_tick
  );

  modport use_side (
    input sys_div_tick,
    input ext_div_tick
  );
endinterface : sdt_tick_if

`default_nettype wire

// [hdl/sdt_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none

module sdt_tick_gen #(
  parameter int SYS_DIV = sdt_pkg::SYS_DIV_COUNT,
  parameter int EXT_DIV = sdt_pkg::EXT_DIV_COUNT
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // External oscillator
  input  wire logic ext_clk,
  // Tick outputs
  sdt_tick_if.gen   ticks
);

  localparam int SW = $clog2(SYS_DIV);
  localparam int EW = $clog2(EXT_DIV);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
  localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

  logic [SW-1:0] sys_cnt_q;
  logic [EW-1:0] ext_cnt_q;
  logic          ext_meta_q;
  logic          ext_sync_q;
  logic          ext_prev_q;
  logic          ext_rise;

  // System clock divider
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sys_cnt_q <= '0;
    end else if (sys_cnt_q == SYS_LAST) begin
      sys_cnt_q <= '0;
    end else begin
      sys_cnt_q <= sys_cnt_q + SW'(1);
    end
  end

  assign ticks.sys_div_tick = (sys_cnt_q == SYS_LAST);

  // External clock synchroniser and edge detect
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_clk;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  assign ext_rise = ext_sync_q & ~ext_prev_q;

  // External clock divider
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_cnt_q <= '0;
    end else if (ext_rise) begin
      ext_cnt_q <= (ext_cnt_q == EXT_LAST) ? '0 : ext_cnt_q + EW'(1);
    end
  end

  assign ticks.ext_div_tick = ext_rise & (ext_cnt_q == EXT_LAST);

endmodule : sdt_tick_gen

`default_nettype wire

// [hdl/sdt_split_timer.sv]
// Functional notes
// - With the split bit set the timer runs as two separate 8-bit counters.
// - Each 8-bit counter reloads from its own reload value on overflow.
// - The run bit starts and stops only the upper counter in split mode.
// - The lower counter counts continuously in split mode.
// - Upper clock: select high gives system clock, else div-12 or ext div-8.
// - Lower clock follows the same choice with its own select bit.
// - The upper overflow flag (bit 7) is set when the upper counter wraps.
// - The lower overflow flag (bit 6) is set when the lower counter wraps.
// - With the timer interrupt enabled, every upper overflow interrupts.
// - With the lower enable also set, either counter's overflow interrupts.
// - Hardware never clears the flags; software clears them by writing.
// - The external clock is synchronised, then divided, before use as an enable.
`timescale 1ns/1ps
`default_nettype none

module sdt_split_timer #(
  parameter int SYS_DIV = sdt_pkg::SYS_DIV_COUNT,
  parameter int EXT_DIV = sdt_pkg::EXT_DIV_COUNT
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Special-function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output var  logic [7:0] sfr_rdata,
  // Reload values
  input  wire logic [7:0] lower_reload_value,
  input  wire logic [7:0] upper_reload_value,
  // Clock source selects from the prescale control register
  input  wire logic       upper_clock_select,
  input  wire logic       lower_clock_select,
  // Timer interrupt enable from the interrupt-enable register
  input  wire logic       timer_irq_enable,
  // External oscillator
  input  wire logic       ext_clk,
  // Counter values
  output var  logic [7:0] lower_counter_byte,
  output var  logic [7:0] upper_counter_byte,
  // Interrupt request
  output var  logic       irq
);

  logic [7:0] timer_two_control_q;
  logic [7:0] timer_two_control_d;
  logic       ctrl_wr;
  logic       split_mode_select;
  logic       run_control;
  logic       external_clock_select;
  logic       lower_overflow_irq_enable;
  logic [1:0] tick_en;
  logic [1:0] ovf;
  logic [1:0] clk_sel;
  logic [7:0] reload [2];
  logic [7:0] count_q [2];
  logic       irq_q;

  sdt_tick_if ticks ();

  sdt_tick_gen #(
    .SYS_DIV (SYS_DIV),
    .EXT_DIV (EXT_DIV)
  ) u_tick_gen (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .ext_clk (ext_clk),
    .ticks   (ticks)
  );

  // Picks the tick for one counter from its select bit
  function automatic logic pick_tick(input logic sel, input logic ext_sel,
                                     input logic sys_div_tick,
                                     input logic ext_div_tick);
    if (sel) begin
      pick_tick = 1'b1;
    end else if (ext_sel) begin
      pick_tick = ext_div_tick;
    end else begin
      pick_tick = sys_div_tick;
    end
  endfunction : pick_tick

  assign split_mode_select =
    timer_two_control_q[sdt_pkg::SPLIT_BIT];
  assign run_control = timer_two_control_q[sdt_pkg::RUN_BIT];
  assign external_clock_select =
    timer_two_control_q[sdt_pkg::EXT_SEL_BIT];
  assign lower_overflow_irq_enable =
    timer_two_control_q[sdt_pkg::LOWER_IRQ_BIT];

  assign clk_sel[sdt_pkg::LOWER_IDX] = lower_clock_select;
  assign clk_sel[sdt_pkg::UPPER_IDX] = upper_clock_select;
  assign reload[sdt_pkg::LOWER_IDX]  = lower_reload_value;
  assign reload[sdt_pkg::UPPER_IDX]  = upper_reload_value;

  // Count enables
  always_comb begin
    tick_en[sdt_pkg::LOWER_IDX] = split_mode_select &
      pick_tick(clk_sel[sdt_pkg::LOWER_IDX], external_clock_select,
                ticks.sys_div_tick, ticks.ext_div_tick);
    tick_en[sdt_pkg::UPPER_IDX] = split_mode_select & run_control &
      pick_tick(clk_sel[sdt_pkg::UPPER_IDX], external_clock_select,
                ticks.sys_div_tick, ticks.ext_div_tick);
  end

  // The two 8-bit counters
  for (genvar i = 0; i < 2; i++) begin : g_cnt
    assign ovf[i] = tick_en[i] & (count_q[i] == sdt_pkg::COUNT_MAX);

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        count_q[i] <= sdt_pkg::COUNT_RESET;
      end else if (ovf[i]) begin
        count_q[i] <= reload[i];
      end else if (tick_en[i]) begin
        count_q[i] <= count_q[i] + 8'h01;
      end
    end
  end

  assign lower_counter_byte = count_q[sdt_pkg::LOWER_IDX];
  assign upper_counter_byte = count_q[sdt_pkg::UPPER_IDX];

  // Control register write; a new overflow wins over a clearing write
  assign ctrl_wr = sfr_wr & (sfr_addr == sdt_pkg::CTRL_ADDR);

  always_comb begin
    timer_two_control_d = timer_two_control_q;
    if (ctrl_wr) begin
      timer_two_control_d = sfr_wdata & sdt_pkg::CTRL_RW_MASK;
    end
    if (ovf[sdt_pkg::UPPER_IDX]) begin
      timer_two_control_d[sdt_pkg::UPPER_FLAG_BIT] = 1'b1;
    end
    if (ovf[sdt_pkg::LOWER_IDX]) begin
      timer_two_control_d[sdt_pkg::LOWER_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timer_two_control_q <= sdt_pkg::CTRL_RESET;
    end else begin
      timer_two_control_q <= timer_two_control_d;
    end
  end

  // Register read; other addresses return zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && sfr_addr == sdt_pkg::CTRL_ADDR) begin
      sfr_rdata <= timer_two_control_q;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // Interrupt level
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= timer_irq_enable &
        (timer_two_control_q[sdt_pkg::UPPER_FLAG_BIT] |
         (lower_overflow_irq_enable &
          timer_two_control_q[sdt_pkg::LOWER_FLAG_BIT]));
    end
  end

  assign irq = irq_q;

endmodule : sdt_split_timer

`default_nettype wire

// [tb/sdt_split_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sdt_split_chk #(
  parameter int SYS_DIV = sdt_pkg::SYS_DIV_COUNT,
  parameter int EXT_DIV = sdt_pkg::EXT_DIV_COUNT
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Counter side
  input wire logic [7:0] lower_reload_value,
  input wire logic [7:0] upper_reload_value,
  input wire logic       upper_clock_select,
  input wire logic       lower_clock_select,
  input wire logic       timer_irq_enable,
  input wire logic [7:0] lower_counter_byte,
  input wire logic [7:0] upper_counter_byte,
  input wire logic       irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  lower_reload_a: assert property ($changed(lower_counter_byte) &&
    $past(lower_counter_byte) == 8'hff |-> lower_counter_byte ==
    $past(lower_reload_value)) else $error("Bad lower reload");
  upper_reload_a: assert property ($changed(upper_counter_byte) &&
    $past(upper_counter_byte) == 8'hff |-> upper_counter_byte ==
    $past(upper_reload_value)) else $error("Bad upper reload");
  lower_step_a: assert property ($changed(lower_counter_byte) &&
    $past(lower_counter_byte) != 8'hff |-> lower_counter_byte ==
    $past(lower_counter_byte) + 8'h01) else $error("Bad lower step");
  upper_step_a: assert property ($changed(upper_counter_byte) &&
    $past(upper_counter_byte) != 8'hff |-> upper_counter_byte ==
    $past(upper_counter_byte) + 8'h01) else $error("Bad upper step");
  read_idle_a: assert property (!$past(sfr_rd && sfr_addr == 8'hc8)
    |-> sfr_rdata == 8'h00) else $error("Read data not idle");
  read_reserved_a: assert property ((sfr_rdata & 8'h12) == 8'h00)
    else $error("Unused bits read high");
  irq_gate_a: assert property (!$past(timer_irq_enable) |-> !irq)
    else $error("Request while disabled");
  lower_gap_a: assert property ($changed(lower_counter_byte) &&
    !lower_clock_select |=> lower_clock_select ||
    $stable(lower_counter_byte)) else $error("Lower ticks too close");
  upper_gap_a: assert property ($changed(upper_counter_byte) &&
    !upper_clock_select |=> upper_clock_select ||
    $stable(upper_counter_byte)) else $error("Upper ticks too close");
endmodule : sdt_split_chk
bind sdt_split_timer sdt_split_chk #(.SYS_DIV(SYS_DIV),
  .EXT_DIV(EXT_DIV)) i_chk (.*);
`default_nettype wire

// [tb/sdt_split_timer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sdt_split_timer_tb_top;
  logic        ref_clk, resetn, sfr_wr, sfr_rd, irq, ext_clk, eirq, cmp;
  logic        upper_clock_select, lower_clock_select, timer_irq_enable;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, lower_counter_byte;
  logic [7:0]  upper_counter_byte, lower_reload_value, upper_reload_value;
  logic [7:0]  mf, erd, nc;
  int          ml, mu, n_mismatch, samples_checked;
  logic [31:0] seed = 32'h7a37;

  sdt_split_timer #(.SYS_DIV(4)) i_dut (.*);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  always #50 ref_clk = ~ref_clk;

  // Random enable and external oscillator
  always @(posedge ref_clk) begin
    seed = lfsr(seed);
    timer_irq_enable <= seed[0] | seed[1];
    ext_clk <= ~ext_clk;
  end

  // Reference model, system clock selects only
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {ml, mu} = '0;
      {mf, erd, eirq} = '0;
    end else begin
      eirq = timer_irq_enable & (mf[7] | (mf[5] & mf[6]));
      erd = (sfr_rd && sfr_addr == 8'hc8) ? mf : 8'h00;
      nc = mf;
      if (sfr_wr && sfr_addr == 8'hc8) mf = sfr_wdata & 8'hed;
      if (nc[3] && lower_clock_select) begin
        if (ml == 255) mf[6] = 1'b1;
        ml = (ml == 255) ? int'(lower_reload_value) : ml + 1;
      end
      if (nc[3] && nc[2] && upper_clock_select) begin
        if (mu == 255) mf[7] = 1'b1;
        mu = (mu == 255) ? int'(upper_reload_value) : mu + 1;
      end
    end
  end

  always @(negedge ref_clk) begin
    if (resetn && cmp) begin
      chk("irq", {7'h00, irq}, {7'h00, eirq});
      chk("rdata", sfr_rdata, erd);
      chk("lower", lower_counter_byte, ml[7:0]);
      chk("upper", upper_counter_byte, mu[7:0]);
    end
  end

  task automatic chk(input string nm, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // One register write or read
  task automatic acc(input logic [7:0] a, d, input logic w);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= w;
    sfr_rd <= ~w;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
  endtask : acc

  // Spacing of lower counter ticks
  task automatic gap_is(input int exp);
    int c, t0, k;
    logic [7:0] v;
    k = 0;
    t0 = 0;
    v = lower_counter_byte;
    for (c = 0; c < 200 && k < 3; c++) begin
      @(negedge ref_clk);
      if (lower_counter_byte !== v) begin
        k++;
        if (k == 3) chk("gap", 8'(c - t0), 8'(exp));
        t0 = c;
        v = lower_counter_byte;
      end
    end
    if (k < 3) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : gap_is

  initial begin
    {ref_clk, resetn, sfr_wr, sfr_rd, ext_clk, timer_irq_enable, cmp} = '0;
    {sfr_addr, sfr_wdata} = '0;
    {lower_clock_select, upper_clock_select} = 2'b11;
    lower_reload_value = seed[7:0];
    upper_reload_value = seed[15:8];
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    cmp = 1'b1;
    acc(8'hc8, 8'h00, 1'b0);
    acc(8'h55, 8'hff, 1'b1);
    acc(8'h55, 8'h00, 1'b0);
    acc(8'hc8, 8'h2c, 1'b1);
    repeat (600) @(posedge ref_clk);
    acc(8'hc8, 8'h28, 1'b1);
    repeat (300) @(posedge ref_clk);
    acc(8'hc8, 8'he4, 1'b1);
    repeat (20) @(posedge ref_clk);
    acc(8'hc8, 8'h00, 1'b0);
    acc(8'hc8, 8'h0c, 1'b1);
    acc(8'hc8, 8'h00, 1'b0);
    cmp = 1'b0;
    lower_clock_select <= 1'b0;
    upper_clock_select <= 1'b0;
    gap_is(4);
    acc(8'hc8, 8'h0d, 1'b1);
    gap_is(16);
    wrap_up();
  end
endmodule : sdt_split_timer_tb_top
`default_nettype wire
